// >>> inc/csf_pkg.sv
// Purpose: Shared constants, types and helpers for the channel shutdown and fault status block.
// Assumes: 250 MHz reference clock; timing words arrive as 5-bit exponent, 11-bit mantissa.
// Notes: Quarter-millisecond ticks are the base unit of every shutdown timer.
package csf_pkg;
    localparam int CLK_NS = 4;
    localparam int TICK_NS = 250000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int QPMS = 4;
    localparam int STOP_MAX_MS = 16000;
    localparam int RAMP_MAX_MS = 1300;
    localparam logic [15:0] STOP_MAX_Q = 16'(STOP_MAX_MS * QPMS);
    localparam logic [15:0] RAMP_MAX_Q = 16'(RAMP_MAX_MS * QPMS);
    localparam logic [15:0] RAMP_MIN_Q = 16'h0001;
    localparam logic [15:0] WATCH_MAX_Q = 16'hFFFF;
    localparam int FIX_FRAC = 8;
    localparam int MS_TO_Q_SHIFT = 6;
    localparam int VOUT_FRAC = 12;
    localparam int OFF_SHIFT = 3;
    localparam int SLOPE_FRAC = 14;
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [7:0] CMD_HOT_FAULT = 8'h4F;
    localparam logic [7:0] CMD_HOT_WARN = 8'h51;
    localparam logic [7:0] CMD_COLD_FAULT = 8'h53;
    localparam logic [7:0] CMD_STOP_DELAY = 8'h64;
    localparam logic [7:0] CMD_RAMP_DOWN = 8'h65;
    localparam logic [7:0] CMD_OFF_WARN = 8'h66;
    localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
    localparam logic [7:0] CMD_STAT_WORD = 8'h79;
    localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7A;
    localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7B;
    localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7C;
    localparam logic [7:0] CMD_TEMP_FLAGS = 8'h7D;
    localparam logic [7:0] CMD_CML_FLAGS = 8'h7E;
    localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h80;
    localparam logic [7:0] CMD_MAKER_INFO = 8'hB6;
    localparam logic [7:0] CMD_CHAN_SETUP = 8'hD0;
    localparam logic [7:0] CMD_SW_CONFIG = 8'hD4;
    localparam logic [7:0] CMD_PAD_STATE = 8'hE5;
    localparam logic [7:0] CMD_GENERIC = 8'hEF;
    localparam logic [7:0] CMD_SLOPE = 8'hF8;
    localparam logic [7:0] CMD_ADDEND = 8'hF9;
    localparam logic [15:0] RST_HOT_FAULT = 16'hEB20;
    localparam logic [15:0] RST_HOT_WARN = 16'hEAA8;
    localparam logic [15:0] RST_COLD_FAULT = 16'hE580;
    localparam logic [15:0] RST_SLOPE = 16'h4000;
    localparam logic [15:0] RST_ADDEND = 16'h8000;
    localparam logic [15:0] RST_STOP_DELAY = 16'h8000;
    localparam logic [15:0] RST_RAMP_DOWN = 16'hD200;
    localparam logic [15:0] RST_OFF_WARN = 16'hF258;
    localparam int SB_BUSY = 7;
    localparam int SB_OFF = 6;
    localparam int SB_OV = 5;
    localparam int SB_OC = 4;
    localparam int SB_TEMP = 2;
    localparam int SB_CML = 1;
    localparam int SB_OTHER = 0;
    localparam int WH_VOUT = 7;
    localparam int WH_IOUT = 6;
    localparam int WH_INPUT = 5;
    localparam int WH_MFR = 4;
    localparam int WH_PGN = 3;
    localparam int VF_OV = 7;
    localparam int VF_TOFF = 1;
    localparam int IF_OC = 7;
    localparam int IN_OV = 7;
    localparam int TF_OT = 7;
    localparam int TF_OTW = 6;
    localparam int TF_UT = 4;
    localparam int CML_BAD_CMD = 7;
    localparam int CML_BAD_DATA = 6;
    localparam int SETUP_NO_TOFF = 0;
    localparam int SW_CCM = 0;
    localparam int SW_TEMP_VOLTS = 5;
    localparam int GEN_NO_ALERT = 7;
    localparam logic [7:0] CML_MASK = 8'hFB;
    localparam logic [7:0] VENDOR_MASK = 8'hFB;
    localparam logic [15:0] MAKER_INFO_DEF = 16'h5A5A;

    typedef enum logic [2:0] {
        CSF_ON = 3'b000,
        CSF_DELAY = 3'b001,
        CSF_RAMP = 3'b011,
        CSF_WATCH = 3'b010,
        CSF_OFF = 3'b110
    } csf_state_t;

    typedef enum logic [1:0] {
        CSF_K_READ = 2'h0,
        CSF_K_WRITE = 2'h1,
        CSF_K_SEND = 2'h2
    } csf_kind_t;

    // Fixed point with FIX_FRAC fraction bits; large exponents may overflow, limits clip later.
    function automatic logic signed [31:0] l11_fix(input logic [15:0] v);
        int e;
        logic signed [31:0] m;
        e = int'($signed(v[15:11]));
        m = $signed({{21{v[10]}}, v[10:0]}) <<< FIX_FRAC;
        if (e < 0) begin
            l11_fix = m >>> (-e);
        end else begin
            l11_fix = m <<< e;
        end
    endfunction : l11_fix

    function automatic logic [15:0] ms_to_q(input logic [15:0] v, input logic [15:0] cap);
        logic signed [31:0] f;
        f = l11_fix(v) >>> MS_TO_Q_SHIFT;
        if (f < 0) begin
            ms_to_q = 16'h0000;
        end else if (f > $signed({16'h0000, cap})) begin
            ms_to_q = cap;
        end else begin
            ms_to_q = f[15:0];
        end
    endfunction : ms_to_q
endpackage : csf_pkg

// >>> design/csf_top.sv
// Purpose: Two-channel shutdown sequencing, external temperature limits and fault status.
// Assumes: Serial transactions arrive decoded as one-cycle command strobes; inputs synchronous.
// Notes: Turn-on sequencing is outside this block; a restart waits until the channel is off.
// Functional notes
// - After stop, wait the programmed stop delay, zero to sixteen seconds.
// - During ramp-down, lower the commanded output linearly from target to zero.
// - At the end of ramp-down, disable the channel's PWM output.
// - Keep the programmed conduction mode throughout ramp-down.
// - Ramps shorter than 0.25 ms or faster than 4 V/ms become 0.25 ms.
// - Ramp-down duration never exceeds 1.3 seconds.
// - After ramp-down, run an off-timeout and warn if output stays on.
// - Output counts as off below 12.5 percent of the target level.
// - An off-timeout value of zero disables the off-timeout warning.
// - Channel setup bit 0 set also skips the off-timeout check.
// - Switching config bit 5 selects volts, else Celsius, for temperature addend.
// - Temperature slope is a 16-bit two's complement word.
// - Overtemperature fault above hot fault threshold; reset value given.
// - Undertemperature fault below cold fault threshold; reset value given.
// - Hot warning sets summary temperature bit, warning flag and alert.
// - Summary bit 6 set whenever the channel supplies no output power.
// - Summary bit 7 set when the device could not answer a request.
// - Summary bits: 5 overvoltage, 4 overcurrent, 3 zero, 2 temp, 1 comm, 0 other.
// - Summary bits 7 and 0 raise alert and clear on write-one.
// - Fault wipe send-byte code clears every set fault bit.
// - Input and comm flags are shared; other status registers follow the page.
// - Low byte of the wide summary equals the critical summary byte.
// - Temperature flags use bits 7, 6 and 4; others read zero.
module csf_top
    import csf_pkg::*;
#(
    parameter int TICK = TICK_CYC,
    parameter logic [15:0] MAKER_INFO = MAKER_INFO_DEF
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_kind,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_done,
    output logic [15:0] cmd_rdata,
    input wire logic [1:0] run_req,
    input wire logic [1:0][15:0] target_output_level,
    input wire logic [1:0][15:0] vout_meas,
    input wire logic [1:0][15:0] ext_temp_raw,
    input wire logic [1:0] over_voltage_flag,
    input wire logic [1:0] over_current_flag,
    input wire logic busy_evt,
    input wire logic [1:0] other_evt,
    input wire logic vin_ov_evt,
    input wire logic [7:0] cml_evt,
    input wire logic [1:0][7:0] vendor_evt,
    input wire logic [1:0] power_good_n,
    input wire logic [15:0] pads_in,
    output logic [1:0] pwm_en,
    output logic [1:0][15:0] cmd_level,
    output logic [1:0] ccm_mode,
    output logic [1:0] temp_addend_volts,
    output logic alert_n
);
    typedef struct packed {
        csf_state_t [1:0] st;
        logic [1:0][15:0] cnt;
        logic [1:0][31:0] rleft;
        logic [1:0][31:0] racc;
        logic [1:0][31:0] rn;
        logic [1:0][15:0] level;
        logic [1:0][15:0] stopd;
        logic [1:0][15:0] rampd;
        logic [1:0][15:0] offw;
        logic [1:0][7:0] setup;
        logic [1:0][7:0] swcfg;
        logic [1:0][15:0] slope;
        logic [1:0][15:0] addend;
        logic [1:0][15:0] hotf;
        logic [1:0][15:0] hotw;
        logic [1:0][15:0] coldf;
        logic [1:0] sb_busy;
        logic [1:0] sb_other;
        logic [1:0][7:0] vflags;
        logic [1:0][7:0] iflags;
        logic [1:0][7:0] tflags;
        logic [1:0][7:0] mflags;
        logic [7:0] inflags;
        logic [7:0] comm_mem_logic_bit;
        logic page;
        logic [31:0] tick_cnt;
        logic [15:0] rdata;
        logic done;
        logic alert;
    } csf_regs_t;

    csf_regs_t q;
    csf_regs_t d;
    logic tick;
    logic [1:0][7:0] sbyte;
    logic [1:0][7:0] whigh;

    function automatic logic signed [31:0] temp_calc(input logic [15:0] raw,
            input logic [15:0] slope, input logic [15:0] addend, input logic volts);
        logic signed [31:0] rf;
        logic signed [47:0] p;
        rf = l11_fix(raw);
        p = $signed({{16{rf[31]}}, rf}) * $signed({{32{slope[15]}}, slope});
        temp_calc = 32'(p >>> SLOPE_FRAC);
        if (!volts) begin
            temp_calc = temp_calc + l11_fix(addend);
        end
    endfunction : temp_calc

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            pwm_en[c] = (q.st[c] == CSF_ON) || (q.st[c] == CSF_DELAY)
                || (q.st[c] == CSF_RAMP);
            sbyte[c] = 8'h00;
            sbyte[c][SB_BUSY] = q.sb_busy[c];
            sbyte[c][SB_OFF] = !pwm_en[c];
            sbyte[c][SB_OV] = q.vflags[c][VF_OV];
            sbyte[c][SB_OC] = q.iflags[c][IF_OC];
            sbyte[c][SB_TEMP] = |q.tflags[c];
            sbyte[c][SB_CML] = |q.comm_mem_logic_bit;
            sbyte[c][SB_OTHER] = q.sb_other[c];
            whigh[c] = 8'h00;
            whigh[c][WH_VOUT] = |q.vflags[c];
            whigh[c][WH_IOUT] = |q.iflags[c];
            whigh[c][WH_INPUT] = |q.inflags;
            whigh[c][WH_MFR] = |q.mflags[c];
            whigh[c][WH_PGN] = power_good_n[c];
        end
    end

    always_comb begin
        logic [15:0] rq;
        logic [31:0] acc;
        logic signed [31:0] t;
        logic [15:0] tgt;
        logic pg;
        logic nochk;
        d = q;
        rq = 16'h0000;
        acc = 32'h0;
        t = 32'sh0;
        tgt = 16'h0000;
        pg = q.page;
        nochk = 1'b0;
        d.done = 1'b0;
        tick = (q.tick_cnt == 32'(TICK - 1));
        d.tick_cnt = tick ? 32'h0 : q.tick_cnt + 32'h1;

        // Clears are applied first so that a same-cycle event below still wins.
        if (cmd_valid) begin
            d.done = 1'b1;
            case (cmd_kind)
                CSF_K_SEND: begin
                    if (cmd_code == CMD_CLEAR) begin
                        d.sb_busy = '0;
                        d.sb_other = '0;
                        d.vflags = '0;
                        d.iflags = '0;
                        d.tflags = '0;
                        d.mflags = '0;
                        d.inflags = '0;
                        d.comm_mem_logic_bit = '0;
                    end else begin
                        d.comm_mem_logic_bit[CML_BAD_CMD] = 1'b1;
                    end
                end
                CSF_K_WRITE: begin
                    case (cmd_code)
                        CMD_PAGE: d.page = cmd_wdata[0];
                        CMD_STOP_DELAY: d.stopd[pg] = cmd_wdata;
                        CMD_RAMP_DOWN: d.rampd[pg] = cmd_wdata;
                        CMD_OFF_WARN: d.offw[pg] = cmd_wdata;
                        CMD_CHAN_SETUP: d.setup[pg] = cmd_wdata[7:0];
                        CMD_SW_CONFIG: d.swcfg[pg] = cmd_wdata[7:0];
                        CMD_SLOPE: d.slope[pg] = cmd_wdata;
                        CMD_ADDEND: d.addend[pg] = cmd_wdata;
                        CMD_HOT_FAULT: d.hotf[pg] = cmd_wdata;
                        CMD_HOT_WARN: d.hotw[pg] = cmd_wdata;
                        CMD_COLD_FAULT: d.coldf[pg] = cmd_wdata;
                        CMD_STAT_BYTE, CMD_STAT_WORD: begin
                            if (cmd_wdata[SB_BUSY]) begin
                                d.sb_busy[pg] = 1'b0;
                            end
                            if (cmd_wdata[SB_OTHER]) begin
                                d.sb_other[pg] = 1'b0;
                            end
                        end
                        CMD_VOUT_FLAGS: d.vflags[pg] = q.vflags[pg] & ~cmd_wdata[7:0];
                        CMD_IOUT_FLAGS: d.iflags[pg] = q.iflags[pg] & ~cmd_wdata[7:0];
                        CMD_INPUT_FLAGS: d.inflags = q.inflags & ~cmd_wdata[7:0];
                        CMD_TEMP_FLAGS: d.tflags[pg] = q.tflags[pg] & ~cmd_wdata[7:0];
                        CMD_CML_FLAGS: d.comm_mem_logic_bit = q.comm_mem_logic_bit & ~cmd_wdata[7:0];
                        CMD_VENDOR_FLAGS: d.mflags[pg] = q.mflags[pg] & ~cmd_wdata[7:0];
                        CMD_MAKER_INFO, CMD_PAD_STATE, CMD_GENERIC: begin
                            d.comm_mem_logic_bit[CML_BAD_DATA] = 1'b1;
                        end
                        default: d.comm_mem_logic_bit[CML_BAD_CMD] = 1'b1;
                    endcase
                end
                CSF_K_READ: begin
                    d.rdata = 16'h0000;
                    case (cmd_code)
                        CMD_PAGE: d.rdata = {15'h0000, q.page};
                        CMD_STOP_DELAY: d.rdata = q.stopd[pg];
                        CMD_RAMP_DOWN: d.rdata = q.rampd[pg];
                        CMD_OFF_WARN: d.rdata = q.offw[pg];
                        CMD_CHAN_SETUP: d.rdata = {8'h00, q.setup[pg]};
                        CMD_SW_CONFIG: d.rdata = {8'h00, q.swcfg[pg]};
                        CMD_SLOPE: d.rdata = q.slope[pg];
                        CMD_ADDEND: d.rdata = q.addend[pg];
                        CMD_HOT_FAULT: d.rdata = q.hotf[pg];
                        CMD_HOT_WARN: d.rdata = q.hotw[pg];
                        CMD_COLD_FAULT: d.rdata = q.coldf[pg];
                        CMD_STAT_BYTE: d.rdata = {8'h00, sbyte[pg]};
                        CMD_STAT_WORD: d.rdata = {whigh[pg], sbyte[pg]};
                        CMD_VOUT_FLAGS: d.rdata = {8'h00, q.vflags[pg]};
                        CMD_IOUT_FLAGS: d.rdata = {8'h00, q.iflags[pg]};
                        CMD_INPUT_FLAGS: d.rdata = {8'h00, q.inflags};
                        CMD_TEMP_FLAGS: d.rdata = {8'h00, q.tflags[pg]};
                        CMD_CML_FLAGS: d.rdata = {8'h00, q.comm_mem_logic_bit};
                        CMD_VENDOR_FLAGS: d.rdata = {8'h00, q.mflags[pg]};
                        CMD_MAKER_INFO: d.rdata = MAKER_INFO;
                        CMD_PAD_STATE: d.rdata = pads_in;
                        CMD_GENERIC: d.rdata[GEN_NO_ALERT] = !q.alert;
                        default: d.comm_mem_logic_bit[CML_BAD_CMD] = 1'b1;
                    endcase
                end
                default: d.comm_mem_logic_bit[CML_BAD_CMD] = 1'b1;
            endcase
        end

        for (int c = 0; c < 2; c++) begin
            tgt = target_output_level[c];
            rq = ms_to_q(q.rampd[c], RAMP_MAX_Q);
            if ((rq == 16'h0000) || ({12'h000, tgt} > (28'(rq) << VOUT_FRAC))) begin
                rq = RAMP_MIN_Q;
            end
            nochk = (l11_fix(q.offw[c]) == 32'sh0)
                || q.setup[c][SETUP_NO_TOFF];
            case (q.st[c])
                CSF_OFF: begin
                    d.level[c] = 16'h0000;
                    if (run_req[c]) begin
                        d.st[c] = CSF_ON;
                    end
                end
                CSF_ON: begin
                    d.level[c] = tgt;
                    if (!run_req[c]) begin
                        d.st[c] = CSF_DELAY;
                        d.cnt[c] = ms_to_q(q.stopd[c], STOP_MAX_Q);
                    end
                end
                CSF_DELAY: begin
                    if (q.cnt[c] == 16'h0000) begin
                        d.st[c] = CSF_RAMP;
                        d.rn[c] = 32'(rq) * 32'(TICK);
                        d.rleft[c] = 32'(rq) * 32'(TICK);
                        d.racc[c] = 32'h0;
                    end else if (tick) begin
                        d.cnt[c] = q.cnt[c] - 16'h0001;
                    end
                end
                CSF_RAMP: begin
                    // One count per cycle at most; error accumulation keeps the slope straight.
                    acc = q.racc[c] + {16'h0000, tgt};
                    if (acc >= q.rn[c]) begin
                        acc = acc - q.rn[c];
                        if (q.level[c] != 16'h0000) begin
                            d.level[c] = q.level[c] - 16'h0001;
                        end
                    end
                    d.racc[c] = acc;
                    d.rleft[c] = q.rleft[c] - 32'h1;
                    if (q.rleft[c] <= 32'h1) begin
                        d.level[c] = 16'h0000;
                        d.st[c] = nochk ? CSF_OFF : CSF_WATCH;
                        d.cnt[c] = ms_to_q(q.offw[c], WATCH_MAX_Q);
                    end
                end
                CSF_WATCH: begin
                    if (vout_meas[c] < (tgt >> OFF_SHIFT)) begin
                        d.st[c] = CSF_OFF;
                    end else if (q.cnt[c] == 16'h0000) begin
                        d.vflags[c][VF_TOFF] = 1'b1;
                        d.st[c] = CSF_OFF;
                    end else if (tick) begin
                        d.cnt[c] = q.cnt[c] - 16'h0001;
                    end
                end
                default: d.st[c] = CSF_OFF;
            endcase

            t = temp_calc(ext_temp_raw[c], q.slope[c], q.addend[c],
                q.swcfg[c][SW_TEMP_VOLTS]);
            // Sets are ORed in last, so they win over any clear in this cycle.
            if (t > l11_fix(q.hotf[c])) begin
                d.tflags[c][TF_OT] = 1'b1;
            end
            if (t > l11_fix(q.hotw[c])) begin
                d.tflags[c][TF_OTW] = 1'b1;
            end
            if (t < l11_fix(q.coldf[c])) begin
                d.tflags[c][TF_UT] = 1'b1;
            end
            d.vflags[c][VF_OV] = d.vflags[c][VF_OV] | over_voltage_flag[c];
            d.iflags[c][IF_OC] = d.iflags[c][IF_OC] | over_current_flag[c];
            d.sb_busy[c] = d.sb_busy[c] | busy_evt;
            d.sb_other[c] = d.sb_other[c] | other_evt[c];
            d.mflags[c] = d.mflags[c] | (vendor_evt[c] & VENDOR_MASK);
        end
        d.inflags[IN_OV] = d.inflags[IN_OV] | vin_ov_evt;
        d.comm_mem_logic_bit = (d.comm_mem_logic_bit | cml_evt) & CML_MASK;
        d.alert = (|q.sb_busy) || (|q.sb_other) || (|q.vflags) || (|q.iflags)
            || (|q.tflags) || (|q.mflags) || (|q.inflags) || (|q.comm_mem_logic_bit);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
            for (int c = 0; c < 2; c++) begin
                q.st[c] <= CSF_OFF;
                q.stopd[c] <= RST_STOP_DELAY;
                q.rampd[c] <= RST_RAMP_DOWN;
                q.offw[c] <= RST_OFF_WARN;
                q.slope[c] <= RST_SLOPE;
                q.addend[c] <= RST_ADDEND;
                q.hotf[c] <= RST_HOT_FAULT;
                q.hotw[c] <= RST_HOT_WARN;
                q.coldf[c] <= RST_COLD_FAULT;
            end
        end else begin
            q <= d;
        end
    end

    assign cmd_done = q.done;
    assign cmd_rdata = q.rdata;
    assign cmd_level = q.level;
    assign alert_n = !q.alert;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ccm_mode[c] = q.swcfg[c][SW_CCM];
            temp_addend_volts[c] = q.swcfg[c][SW_TEMP_VOLTS];
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    pwm_stop_end_a: assert property (
        (q.st[0] == CSF_RAMP && q.rleft[0] <= 32'h1) |=> !pwm_en[0] && cmd_level[0] == 16'h0000)
        else $error("pwm still enabled after ramp end");
    ramp_monotone_a: assert property (
        q.st[0] == CSF_RAMP |=> cmd_level[0] <= $past(cmd_level[0]))
        else $error("ramp level rose");
    delay_to_ramp_a: assert property (
        (q.st[0] == CSF_DELAY && q.cnt[0] == 16'h0000) |=> q.st[0] == CSF_RAMP)
        else $error("stop delay did not end in ramp");
    ramp_cap_a: assert property (
        q.st[0] == CSF_RAMP |-> q.rleft[0] <= 32'(RAMP_MAX_Q) * 32'(TICK))
        else $error("ramp longer than cap");
    off_bit_live_a: assert property (
        sbyte[0][SB_OFF] == (q.st[0] == CSF_OFF || q.st[0] == CSF_WATCH)
            && sbyte[0][3] == 1'b0)
        else $error("summary off or zero bit wrong");
    warn_guard_a: assert property (
        $rose(q.vflags[0][VF_TOFF]) |-> $past(q.st[0]) == CSF_WATCH
            && l11_fix($past(q.offw[0])) != 32'sh0 && !$past(q.setup[0][SETUP_NO_TOFF]))
        else $error("off timeout warning raised while disabled");
    wipe_clear_a: assert property (
        (cmd_valid && cmd_kind == CSF_K_SEND && cmd_code == CMD_CLEAR && !busy_evt)
            |=> !q.sb_busy[0] && q.comm_mem_logic_bit == ($past(cml_evt) & CML_MASK))
        else $error("fault wipe left busy bit");
    w1c_other_a: assert property (
        (cmd_valid && cmd_kind == CSF_K_WRITE && cmd_code == CMD_STAT_BYTE && !q.page
            && cmd_wdata[SB_OTHER] && !other_evt[0]) |=> !q.sb_other[0])
        else $error("write one did not clear other bit");
    sticky_temp_a: assert property (
        (q.tflags[0][TF_OT] && !cmd_valid) |=> q.tflags[0][TF_OT])
        else $error("temperature fault bit dropped alone");
    warn_alert_a: assert property (
        q.tflags[0][TF_OTW] |-> sbyte[0][SB_TEMP] ##1 !alert_n)
        else $error("hot warning did not reach summary or alert");
endmodule : csf_top

// >>> tb/csf_host.sv
// Purpose: Host model that issues one command per call.
// Assumes: Each strobe is taken on the next edge.
// Notes: Released code and data lines show inverted values; kind keeps its value.
module csf_host import csf_pkg::*; (
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic [1:0] cmd_kind,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_kind = CSF_K_READ;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // Write-one clears use this same path.
    task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask : xfer
endmodule : csf_host

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the shutdown and status block.
// Assumes: Tick shortened to four cycles.
// Notes: Read results are checked in order from a queue.
module tb_top import csf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, srst = 1'b1, cmd_valid, cmd_done, alert_n, busy = 1'b0;
    logic [1:0] cmd_kind, run = 2'h0, ov = 2'h0, oc = 2'h0, oth = 2'h0, pwm_en, ccm, tv;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, pads = 16'h0000;
    logic [1:0][15:0] tgt = {16'h4000, 16'h0080}, vout = '0, temp = {16'h0019, 16'h0019}, lvl;
    logic [16:0] exp_q[$];
    logic [31:0] lf = 32'h5559;
    int num_errors = 0, tests_run = 0, cyc = 0, n;
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    csf_top #(.TICK(4)) u_csf_top (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
        .cmd_rdata(cmd_rdata), .run_req(run), .target_output_level(tgt), .vout_meas(vout),
        .ext_temp_raw(temp), .over_voltage_flag(ov), .over_current_flag(oc), .busy_evt(busy),
        .other_evt(oth), .vin_ov_evt(1'b0), .cml_evt(8'h00), .vendor_evt(16'h0000),
        .power_good_n(2'h0), .pads_in(pads), .pwm_en(pwm_en), .cmd_level(lvl),
        .ccm_mode(ccm), .temp_addend_volts(tv), .alert_n(alert_n));
    csf_host u_csf_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    task automatic end_sim();
        $display("counts: errors %0d compares %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask : cmp
    task automatic w(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : w
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        exp_q.push_back({1'b1, e});
        u_csf_host.xfer(CSF_K_READ, c, 16'h0000);
    endtask : rd
    task automatic wr(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d);
        exp_q.push_back({1'b0, d});
        u_csf_host.xfer(k, c, d);
    endtask : wr
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            num_errors++;
            end_sim();
        end
        if (cmd_done === 1'b1 && exp_q.size() > 0) begin
            if (exp_q[0][16]) cmp("read data", exp_q[0][15:0], cmd_rdata);
            void'(exp_q.pop_front());
        end
    end
    initial begin
        w(6);
        srst = 1'b0;
        rd(CMD_HOT_FAULT, RST_HOT_FAULT);
        rd(CMD_HOT_WARN, RST_HOT_WARN);
        rd(CMD_COLD_FAULT, RST_COLD_FAULT);
        lf = lfsr(lf);
        pads = lf[31:16];
        wr(CSF_K_WRITE, CMD_SLOPE, lf[15:0]);
        rd(CMD_SLOPE, lf[15:0]);
        rd(CMD_PAD_STATE, lf[31:16]);
        wr(CSF_K_WRITE, CMD_SLOPE, RST_SLOPE);
        wr(CSF_K_SEND, CMD_CLEAR, 16'h0000);
        rd(CMD_STAT_WORD, 16'h0040);
        {busy, oth, ov, oc} = 7'h7F;
        w(1);
        {busy, oth, ov, oc} = 7'h00;
        w(2);
        cmp("alert_n", 16'h0000, {15'h0, alert_n});
        rd(CMD_STAT_BYTE, 16'h00F1);
        wr(CSF_K_WRITE, CMD_STAT_BYTE, 16'h0080);
        rd(CMD_STAT_BYTE, 16'h0071);
        wr(CSF_K_SEND, CMD_CLEAR, 16'h0000);
        rd(CMD_STAT_BYTE, 16'h0040);
        w(2);
        cmp("alert_n", 16'h0001, {15'h0, alert_n});
        $display("test status done");
        temp[0] = 16'h005A;
        w(8);
        rd(CMD_TEMP_FLAGS, 16'h0040);
        rd(CMD_STAT_BYTE, 16'h0044);
        temp[0] = 16'h0065;
        w(8);
        temp[0] = 16'h07D7;
        w(8);
        temp[0] = 16'h0019;
        w(8);
        rd(CMD_TEMP_FLAGS, 16'h00D0);
        wr(CSF_K_WRITE, CMD_PAGE, 16'h0001);
        rd(CMD_TEMP_FLAGS, 16'h0000);
        wr(CSF_K_WRITE, CMD_PAGE, 16'h0000);
        wr(CSF_K_SEND, CMD_CLEAR, 16'h0000);
        $display("test temperature done");
        wr(CSF_K_WRITE, CMD_SW_CONFIG, 16'h0021);
        cmp("addend volts", 16'h0001, {15'h0, tv[0]});
        for (int i = 0; i < 5; i++) begin
            wr(CSF_K_WRITE, CMD_CHAN_SETUP, {15'h0, i == 2});
            if (i == 3) wr(CSF_K_WRITE, CMD_RAMP_DOWN, 16'h8000);
            if (i == 3) wr(CSF_K_WRITE, CMD_STOP_DELAY, 16'h0002);
            if (i == 4) wr(CSF_K_WRITE, CMD_OFF_WARN, 16'h8000);
            vout[0] = (i == 1) ? 16'h000F : 16'h4000;
            run[0] = 1'b1;
            w(4);
            run[0] = 1'b0;
            n = 0;
            while (pwm_en[0] === 1'b1 && n < 400) begin
                if (n == 64 && i < 3) cmp("mid level", 16'h0001, 16'(lvl[0] > 16'h0038 &&
                    lvl[0] < 16'h0048 && ccm[0] === 1'b1));
                w(1);
                n++;
            end
            cmp("ramp", 16'h0001, 16'(n >= ((i >= 3) ? 34 : 126)
                && n <= ((i >= 3) ? 40 : 132)));
            cmp("level", 16'h0000, lvl[0]);
            w(2500);
            rd(CMD_VOUT_FLAGS, (i == 0 || i == 3) ? 16'h0002 : 16'h0000);
            wr(CSF_K_SEND, CMD_CLEAR, 16'h0000);
        end
        $display("test shutdown done");
        w(4);
        cmp("pending", 16'h0000, 16'(exp_q.size()));
        end_sim();
    end
endmodule : tb_top
